// >>> pkg/mss_pkg.sv
`default_nettype none
// =====================================================================
// Shared constants and types of the stream sequencer
package mss_pkg;

    // =================================================================
    // Widths and depths
    localparam int WORD_W = 32;
    localparam int ADDR_W = 15;
    localparam int FIFO_DEPTH = 4;
    localparam int FRAME_CNT_W = 16;
    localparam int BEAT_W = 3;

    // =================================================================
    // Frame timing, in clock cycles
    localparam int FRAME_BEATS = 8;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 3'h0;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 3'h7;

    // =================================================================
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_START = 15'h0000;
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_ZERO = 16'h0000;

    // =================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        MSS_IDLE = 3'h0,
        MSS_ARM = 3'h1,
        MSS_RELEASE = 3'h2,
        MSS_SETUP_A = 3'h3,
        MSS_SETUP_B = 3'h4,
        MSS_PREFETCH = 3'h5,
        MSS_DATA = 3'h6,
        MSS_FINISH = 3'h7
    } mss_state_e;

    // =================================================================
    // Strobes that leave the block together
    typedef struct packed {
        logic frame_sync;
        logic word_valid;
        logic reset_release;
        logic rd_en;
    } mss_strobe_s;

    localparam mss_strobe_s STROBE_IDLE = 4'h0;

endpackage
`default_nettype wire

// >>> src/mss_beat_counter.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Beat counter: counts while run is high, wraps after LAST
module mss_beat_counter #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] LAST = 3'h7,
    parameter logic [WIDTH-1:0] FIRST = 3'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic [WIDTH-1:0] count,
    output logic last
);

    // =================================================================
    // Count; cleared whenever the owner is outside a frame
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            count <= FIRST;
        end
        else if (last)
        begin
            count <= FIRST; // Wrap gives back-to-back frames
        end
        else
        begin
            count <= count + WIDTH'(1);
        end
    end

    // Terminal beat
    assign last = (count == LAST);

endmodule
`default_nettype wire

// >>> src/mss_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Word FIFO, first word falls through; empty FIFO bypasses input
module mss_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
    localparam int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] level
);

    // =================================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic empty;
    logic full;
    logic bypass;
    logic push;
    logic pop;

    // Status and flow terms
    assign empty = (level == CW'(0));
    assign full = (level == CW'(DEPTH));
    assign in_ready = !full;
    assign bypass = empty && in_valid && out_ready;
    assign push = in_valid && !full && !bypass;
    assign pop = out_ready && !empty;
    assign out_valid = !empty || in_valid;
    // Bypass saves a cycle so memory latency stays at one
    assign out_data = empty ? in_data : mem[rd_ptr];

    // Write side
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= PW'(0);
            rd_ptr <= PW'(0);
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? PW'(0) : wr_ptr + PW'(1);
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? PW'(0) : rd_ptr + PW'(1);
            end
        end
    end

    // Fill level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            level <= CW'(0);
        end
        else if (push && !pop)
        begin
            level <= level + CW'(1);
        end
        else if (pop && !push)
        begin
            level <= level - CW'(1);
        end
    end

endmodule
`default_nettype wire

// >>> src/mss_sequencer.sv
// Contract
// R1: After reset wait idle until stream request goes high, then initialise.
// R2: Leaving idle: one pass state, then release held high exactly two cycles.
// R3: Frame sync one-cycle pulse: second release cycle, second setup frame, each data frame.
// R4: Two setup frames of eight cycles each, word valid low throughout.
// R5: Memory read enable rises one cycle before first word valid cycle.
// R6: Each data frame holds word valid high eight cycles, starting with sync.
// R7: Read enable stays high through the last valid cycle, one word per cycle.
// R8: While valid, successive stored words are read and put on the bus.
// R9: Request still high at eighth data cycle: next frame follows with no gap.
// R10: Request low at eighth data cycle: one finish cycle, then idle.
// R11: Both frame sync outputs come from one internal sync signal.
// R12: Both word valid outputs come from one internal valid signal.
// R13: Bus signals are outputs only; nothing is sampled from the bus.
// R14: One clock and one module reset; all outputs synchronous to it.
// R15: Receiver takes one word per valid cycle; sync marks a new frame.
// R16: Outside streaming, valid, sync, release and read enable stay low.
`timescale 1ns/100ps
`default_nettype none
module mss_sequencer #(
    parameter int WORD_W = mss_pkg::WORD_W,
    parameter int ADDR_W = mss_pkg::ADDR_W,
    parameter int FIFO_DEPTH = mss_pkg::FIFO_DEPTH,
    parameter int FRAME_CNT_W = mss_pkg::FRAME_CNT_W,
    localparam int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
    // Single clock and module reset
    input wire logic clk,
    input wire logic rst,
    // Control block
    input wire logic stream_request,
    output logic stream_active,
    output logic [FRAME_CNT_W-1:0] frame_count,
    output logic data_underrun,
    // Storage memory read port
    output logic mem_rd_en,
    output logic [ADDR_W-1:0] mem_rd_addr,
    input wire logic [WORD_W-1:0] mem_rd_data,
    // Multiplexed data bus, output only
    output logic port1_frame_sync,
    output logic port2_frame_sync,
    output logic port1_word_valid,
    output logic port2_word_valid,
    output logic inbuf_reset_release,
    output logic [WORD_W-1:0] mux_data,
    output logic [LVL_W-1:0] fifo_level
);

    // =================================================================
    // Declarations
    mss_pkg::mss_state_e state;
    mss_pkg::mss_state_e next_state;
    mss_pkg::mss_strobe_s strobe;
    mss_pkg::mss_strobe_s next_strobe;
    logic [mss_pkg::BEAT_W-1:0] beat;
    logic beat_last;
    logic beat_first;
    logic in_frame;
    logic mem_data_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic start_stream;
    logic frame_done;

    // =================================================================
    // Beat counting inside each eight-cycle frame
    // Frame states run the counter; any other state parks it at zero
    assign in_frame = (state == mss_pkg::MSS_SETUP_A)
        || (state == mss_pkg::MSS_SETUP_B)
        || (state == mss_pkg::MSS_DATA);

    mss_beat_counter #(
        .WIDTH(mss_pkg::BEAT_W),
        .LAST(mss_pkg::BEAT_LAST),
        .FIRST(mss_pkg::BEAT_FIRST)
    ) u_beat (
        .clk(clk),
        .rst(rst),
        .run(in_frame),
        .count(beat),
        .last(beat_last)
    );

    // First beat of a frame, where sync belongs
    assign beat_first = (beat == mss_pkg::BEAT_FIRST);

    // =================================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= mss_pkg::MSS_IDLE; // [R1] [R14]
        end
        else
        begin
            state <= next_state;
        end
    end

    // =================================================================
    // Next state
    // A drop of the request during setup does not abort the sequence;
    // the request is only looked at in idle and on the last data beat.
    always_comb
    begin
        next_state = state;
        case (state)
            mss_pkg::MSS_IDLE:
            begin
                if (stream_request)
                begin
                    next_state = mss_pkg::MSS_ARM; // [R1]
                end
            end
            mss_pkg::MSS_ARM:
            begin
                next_state = mss_pkg::MSS_RELEASE; // [R2]
            end
            mss_pkg::MSS_RELEASE:
            begin
                next_state = mss_pkg::MSS_SETUP_A; // [R2]
            end
            mss_pkg::MSS_SETUP_A:
            begin
                if (beat_last)
                begin
                    next_state = mss_pkg::MSS_SETUP_B; // [R4]
                end
            end
            mss_pkg::MSS_SETUP_B:
            begin
                if (beat_last)
                begin
                    next_state = mss_pkg::MSS_PREFETCH; // [R4]
                end
            end
            mss_pkg::MSS_PREFETCH:
            begin
                // Hold the prefetch while the buffer cannot take a word
                if (fifo_in_ready)
                begin
                    next_state = mss_pkg::MSS_DATA; // [R5]
                end
            end
            mss_pkg::MSS_DATA:
            begin
                if (beat_last && stream_request)
                begin
                    next_state = mss_pkg::MSS_DATA; // [R9]
                end
                else if (beat_last)
                begin
                    next_state = mss_pkg::MSS_FINISH; // [R10]
                end
            end
            mss_pkg::MSS_FINISH:
            begin
                next_state = mss_pkg::MSS_IDLE; // [R10]
            end
            default:
            begin
                next_state = mss_pkg::MSS_IDLE;
            end
        endcase
    end

    // =================================================================
    // Strobe decode from the current state
    // Decoded here and registered below, so every bus strobe and the
    // read enable leave through flops and keep their relative timing.
    always_comb
    begin
        next_strobe = mss_pkg::STROBE_IDLE; // [R16]
        case (state)
            mss_pkg::MSS_RELEASE:
            begin
                next_strobe.reset_release = 1'b1; // [R2]
            end
            mss_pkg::MSS_SETUP_A:
            begin
                next_strobe.reset_release = beat_first; // [R2]
                next_strobe.frame_sync = beat_first; // [R3] [R4]
            end
            mss_pkg::MSS_SETUP_B:
            begin
                next_strobe.frame_sync = beat_first; // [R3] [R4]
            end
            mss_pkg::MSS_PREFETCH:
            begin
                // Read one cycle ahead to hide the memory latency
                next_strobe.rd_en = fifo_in_ready; // [R5]
            end
            mss_pkg::MSS_DATA:
            begin
                next_strobe.frame_sync = beat_first; // [R3]
                next_strobe.word_valid = 1'b1; // [R6]
                next_strobe.rd_en = 1'b1; // [R7]
            end
            default:
            begin
                next_strobe = mss_pkg::STROBE_IDLE; // [R16]
            end
        endcase
    end

    // Strobe register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strobe <= mss_pkg::STROBE_IDLE; // [R14] [R16]
        end
        else
        begin
            strobe <= next_strobe;
        end
    end

    // =================================================================
    // Memory read side
    assign mem_rd_en = strobe.rd_en; // [R7]

    // Word address advances once per read, restarts with each stream
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_rd_addr <= mss_pkg::ADDR_START;
        end
        else if (state == mss_pkg::MSS_ARM)
        begin
            mem_rd_addr <= mss_pkg::ADDR_START;
        end
        else if (strobe.rd_en)
        begin
            mem_rd_addr <= mem_rd_addr + ADDR_W'(1); // [R8]
        end
    end

    // Memory answers one cycle after the enable. The read in the last
    // valid cycle of a stream fetches a word that no frame takes; keeping
    // it out of the buffer lets the next stream start clean from word zero.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_data_valid <= 1'b0;
        end
        else
        begin
            mem_data_valid <= strobe.rd_en && next_strobe.word_valid; // [R5] [R8]
        end
    end

    // =================================================================
    // Data buffer between memory and bus
    // The bus drains one word per valid cycle; the buffer's ready
    // stalls the prefetch so a word is never read without room.
    mss_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(mem_data_valid),
        .in_ready(fifo_in_ready),
        .in_data(mem_rd_data),
        .out_valid(fifo_out_valid),
        .out_ready(strobe.word_valid),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // Words reach the bus in the valid cycle; zero when not valid
    assign mux_data = strobe.word_valid ? fifo_out_data : '0; // [R8] [R13]

    // =================================================================
    // Bus outputs: both ports from one internal signal each
    assign port1_frame_sync = strobe.frame_sync; // [R11]
    assign port2_frame_sync = strobe.frame_sync; // [R11]
    assign port1_word_valid = strobe.word_valid; // [R12]
    assign port2_word_valid = strobe.word_valid; // [R12]
    assign inbuf_reset_release = strobe.reset_release; // [R2]

    // =================================================================
    // Status toward the control block
    assign start_stream = (state == mss_pkg::MSS_ARM);
    assign frame_done = (state == mss_pkg::MSS_DATA) && beat_last;

    // Busy from leaving idle until back in idle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stream_active <= 1'b0;
        end
        else
        begin
            stream_active <= (next_state != mss_pkg::MSS_IDLE);
        end
    end

    // Data frames sent since the stream began
    always_ff @(posedge clk)
    begin
        if (rst || start_stream)
        begin
            frame_count <= mss_pkg::FRAME_CNT_ZERO;
        end
        else if (frame_done)
        begin
            frame_count <= frame_count + FRAME_CNT_W'(1);
        end
    end

    // Sticky: a valid cycle found no word; cleared at next stream start
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_underrun <= 1'b0;
        end
        else if (strobe.word_valid && !fifo_out_valid)
        begin
            data_underrun <= 1'b1;
        end
        else if (start_stream)
        begin
            data_underrun <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> dv/mss_sequencer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port-level checks of the stream sequencer
module mss_sequencer_assertions #(
    parameter int WORD_W = 32,
    parameter int ADDR_W = 15,
    parameter int FIFO_DEPTH = 4,
    parameter int FRAME_CNT_W = 16,
    localparam int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stream_request,
    input wire logic stream_active,
    input wire logic [FRAME_CNT_W-1:0] frame_count,
    input wire logic data_underrun,
    input wire logic mem_rd_en,
    input wire logic [ADDR_W-1:0] mem_rd_addr,
    input wire logic [WORD_W-1:0] mem_rd_data,
    input wire logic port1_frame_sync,
    input wire logic port2_frame_sync,
    input wire logic port1_word_valid,
    input wire logic port2_word_valid,
    input wire logic inbuf_reset_release,
    input wire logic [WORD_W-1:0] mux_data,
    input wire logic [LVL_W-1:0] fifo_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Start-up and setup frames
    // A fall caused by reset itself is not a setup start
    sequence s_dfirst;
        port1_frame_sync && port1_word_valid;
    endsequence
    property p_start;
        $rose(inbuf_reset_release) |-> $past(stream_request, 3) && !$past(stream_active, 3);
    endproperty
    property p_release;
        $rose(inbuf_reset_release) |=> inbuf_reset_release ##1 !inbuf_reset_release;
    endproperty
    property p_rel_sync;
        inbuf_reset_release && $past(inbuf_reset_release) |-> port1_frame_sync;
    endproperty
    property p_sync_pulse;
        port1_frame_sync |=> !port1_frame_sync;
    endproperty
    property p_setup;
        $fell(inbuf_reset_release) && !$past(rst) |->
            (!port1_frame_sync && !port1_word_valid)[*7] ##1 (port1_frame_sync && !port1_word_valid);
    endproperty
    property p_prefetch;
        $fell(inbuf_reset_release) && !$past(rst) |-> ##8 (!port1_frame_sync && !port1_word_valid)[*7]
            ##1 (mem_rd_en && !port1_word_valid) ##1 s_dfirst;
    endproperty

    // ==========================================================
    // Data frames
    property p_frame;
        s_dfirst |-> port1_word_valid[*8] ##1 (!port1_word_valid || port1_frame_sync);
    endproperty
    property p_rd_cover;
        port1_word_valid |-> mem_rd_en && $past(mem_rd_en);
    endproperty
    property p_data;
        port1_word_valid && fifo_level == '0 |-> mux_data == mem_rd_data;
    endproperty
    property p_chain;
        s_dfirst ##6 stream_request |-> ##2 s_dfirst;
    endproperty
    property p_stop;
        s_dfirst ##6 !stream_request |-> ##1 (stream_active && port1_word_valid)
            ##1 (!stream_active && !port1_word_valid && !mem_rd_en);
    endproperty
    property p_twin;
        port1_frame_sync == port2_frame_sync && port1_word_valid == port2_word_valid;
    endproperty
    property p_quiet;
        !stream_active |-> !(port1_word_valid || port1_frame_sync || inbuf_reset_release
            || mem_rd_en) && mux_data == '0;
    endproperty

    a_start: assert property (p_start) else $error("release without request");
    a_release: assert property (p_release) else $error("release not two cycles");
    a_rel_sync: assert property (p_rel_sync) else $error("no sync in release");
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync too long");
    a_setup: assert property (p_setup) else $error("setup frame wrong");
    a_prefetch: assert property (p_prefetch) else $error("prefetch wrong");
    a_frame: assert property (p_frame) else $error("valid not eight");
    a_rd_cover: assert property (p_rd_cover) else $error("valid without read");
    a_data: assert property (p_data) else $error("data not memory word");
    a_chain: assert property (p_chain) else $error("gap between frames");
    a_stop: assert property (p_stop) else $error("bad stream end");
    a_twin: assert property (p_twin) else $error("ports differ");
    a_quiet: assert property (p_quiet) else $error("strobe while idle");

    c_chain: cover property (s_dfirst ##6 stream_request ##2 s_dfirst);
    c_stop: cover property (s_dfirst ##6 !stream_request ##3 !stream_active);
    c_setup: cover property ($fell(inbuf_reset_release) ##7 port1_frame_sync);
endmodule

bind mss_sequencer mss_sequencer_assertions #(
    .WORD_W(WORD_W),
    .ADDR_W(ADDR_W),
    .FIFO_DEPTH(FIFO_DEPTH),
    .FRAME_CNT_W(FRAME_CNT_W)
) i_chk (.*);
`default_nettype wire

// >>> dv/mss_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Receiving port: one word per valid cycle, sync counts frames
module mss_rx_model (
    input wire logic clk,
    input wire logic clear,
    input wire logic frame_sync,
    input wire logic word_valid,
    input wire logic [31:0] data,
    output logic [7:0] word_cnt,
    output logic [7:0] frame_cnt,
    output logic [31:0] sum
);
    // Xor sum catches order-free word loss cheaply
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            word_cnt <= 8'h0;
            frame_cnt <= 8'h0;
            sum <= 32'h0;
        end
        else
        begin
            if (word_valid)
            begin
                word_cnt <= word_cnt + 8'h1;
                sum <= sum ^ data;
            end
            if (frame_sync)
                frame_cnt <= frame_cnt + 8'h1;
        end
    end
endmodule

// ==========================================================
// Storage port: one cycle read latency, garbage when idle
module mss_mem_model (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [14:0] addr,
    output logic [31:0] data
);
    // Inverting stale data keeps a missed enable visible
    always_ff @(posedge clk)
    begin
        if (rd_en)
            data <= 32'h5a5a0000 ^ {17'h0, addr};
        else
            data <= ~data;
    end
endmodule
`default_nettype wire

// >>> dv/mss_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Self-checking bench of the stream sequencer
module mss_sequencer_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stream_request = 1'b0;
    logic rx_clear = 1'b1;
    logic stream_active, data_underrun, mem_rd_en, inbuf_reset_release;
    logic port1_frame_sync, port2_frame_sync, port1_word_valid, port2_word_valid;
    logic [15:0] frame_count;
    logic [14:0] mem_rd_addr;
    logic [31:0] mem_rd_data, mux_data, s1, s2;
    logic [2:0] fifo_level;
    logic [7:0] w1, f1, w2, f2;
    int mismatches = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    mss_sequencer i_dut (.*);
    mss_mem_model i_mem (.clk(clk), .rd_en(mem_rd_en), .addr(mem_rd_addr), .data(mem_rd_data));
    mss_rx_model i_rx1 (.clk(clk), .clear(rx_clear), .frame_sync(port1_frame_sync),
        .word_valid(port1_word_valid), .data(mux_data), .word_cnt(w1), .frame_cnt(f1), .sum(s1));
    mss_rx_model i_rx2 (.clk(clk), .clear(rx_clear), .frame_sync(port2_frame_sync),
        .word_valid(port2_word_valid), .data(mux_data), .word_cnt(w2), .frame_cnt(f2), .sum(s2));

    // ==========================================================
    // Shared helpers
    function automatic logic [31:0] pat(input int i);
        return 32'h5a5a0000 ^ 32'(i);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // Request low: nothing may leave idle
    task automatic t_idle();
        repeat (20)
        begin
            @(negedge clk);
            check({stream_active, port1_word_valid, port1_frame_sync, mem_rd_en}, 32'h0);
            check(mux_data, 32'h0);
            check(inbuf_reset_release, 1'b0);
        end
    endtask

    // One stream of given frames; request dropped in cycle drop
    task automatic run_stream(input int frames, input int drop);
        int last;
        logic e_sync;
        logic e_valid;
        logic [31:0] sum;
        last = 20 + 8 * frames;
        sum = 32'h0;
        rx_clear = 1'b1;
        stream_request = 1'b1;
        for (int k = 1; k <= last + 2; k++)
        begin
            @(negedge clk);
            rx_clear = 1'b0;
            if (k == drop)
                stream_request = 1'b0;
            e_valid = k > 20 && k <= last;
            e_sync = k == 4 || k == 12 || (e_valid && (k - 21) % 8 == 0);
            if (e_valid)
                sum = sum ^ pat(k - 21);
            check(inbuf_reset_release, k == 3 || k == 4);
            check({port1_frame_sync, port2_frame_sync}, {2{e_sync}});
            check({port1_word_valid, port2_word_valid}, {2{e_valid}});
            check(mem_rd_en, k >= 20 && k <= last);
            check(stream_active, k >= 1 && k <= last);
            check(mux_data, e_valid ? pat(k - 21) : 32'h0);
            if (k >= 20 && k <= last)
                check(mem_rd_addr, k - 20);
        end
        check(frame_count, frames);
        check({w1, f1, w2, f2}, {2{8'(8 * frames), 8'(frames + 2)}});
        check(s1, sum);
        check(s2, sum);
        check({data_underrun, fifo_level}, 4'h0);
    endtask

    // Reset in mid-frame must silence busy, port 1 valid and sync, read enable and release at once
    task automatic t_reset_mid();
        stream_request = 1'b1;
        repeat (25) @(negedge clk);
        rst = 1'b1;
        stream_request = 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            check({stream_active, port1_word_valid, port1_frame_sync, mem_rd_en}, 32'h0);
            check(inbuf_reset_release, 1'b0);
        end
        rst = 1'b0;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        // Reset spans four rising edges
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_idle();
        run_stream(1, 5);
        run_stream(3, 37);
        run_stream(2, 29);
        t_reset_mid();
        run_stream(1, 21);
        stop_test();
    end

    // Run needs about 200 cycles; allow far more
    initial
    begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
